// ### core/iei_pkg.sv
`default_nettype none
package iei_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned PRESET_W = 15;
    localparam int unsigned ACC_W = 15;
    localparam int unsigned PCLK_PERIOD_NS = 10;
    localparam int unsigned SWITCH_TIME_MS = 1;
    localparam int unsigned SWITCH_CYC = (SWITCH_TIME_MS * 1000000) / PCLK_PERIOD_NS;
    localparam int unsigned DETECT_TIME_US = 100;
    localparam int unsigned DETECT_CYC = (DETECT_TIME_US * 1000) / PCLK_PERIOD_NS;
    localparam int unsigned WDOG_TIME_MS = 500;
    localparam int unsigned WDOG_CYC = (WDOG_TIME_MS * 1000000) / PCLK_PERIOD_NS;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESET = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_COMPARE = 8'h0C;
    localparam logic [7:0] ADDR_GROUP = 8'h10;
    localparam logic [7:0] ADDR_CHANGED = 8'h14;
    localparam logic [7:0] ADDR_ACCUM = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_HANDLER = 8'h24;
    localparam logic [7:0] ADDR_STATE = 8'h28;

    localparam int unsigned CTRL_MODE_BIT = 0;
    localparam int unsigned HND_DONE_BIT = 0;
    localparam int unsigned HND_BT_BIT = 1;
    localparam int unsigned HND_KICK_BIT = 2;
    localparam int unsigned GROUP_RACK_LSB = 4;
    localparam logic [3:0] LOCAL_RACK = 4'h0;

    localparam int unsigned ST_W = 5;
    localparam int unsigned ST_TAKEN = 0;
    localparam int unsigned ST_OVERLAP = 1;
    localparam int unsigned ST_NOT_LOCAL = 2;
    localparam int unsigned ST_DONE = 3;
    localparam int unsigned ST_WDOG = 4;

    localparam logic [PRESET_W-1:0] PRESET_RST = 15'h0000;
    localparam logic [WORD_W-1:0] MASK_RST = 16'h0000;
    localparam logic [WORD_W-1:0] COMPARE_RST = 16'h0000;
    localparam logic [7:0] GROUP_RST = 8'h00;

    typedef enum logic [3:0] {
        IEI_MAIN = 4'b0001,
        IEI_SW_IN = 4'b0010,
        IEI_HANDLER = 4'b0100,
        IEI_SW_OUT = 4'b1000
    } iei_state_t;

    typedef struct packed {
        logic counter_mode;
        logic [PRESET_W-1:0] preset;
        logic [WORD_W-1:0] mask;
        logic [WORD_W-1:0] compare;
        logic [7:0] group;
    } iei_cfg_t;

    localparam iei_cfg_t CFG_RST = '{1'b0, PRESET_RST, MASK_RST, COMPARE_RST, GROUP_RST};
endpackage : iei_pkg
`default_nettype wire

// ### core/iei_edge.sv
`timescale 1ns/1ps
`default_nettype none
module iei_edge (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [iei_pkg::WORD_W-1:0] din, // monitored input word
    input wire logic [iei_pkg::WORD_W-1:0] mask, // monitor enable per bit
    input wire logic [iei_pkg::WORD_W-1:0] compare, // 1 rising, 0 falling
    output logic [iei_pkg::WORD_W-1:0] hit // qualifying transition per bit
);
    import iei_pkg::*;
    logic [WORD_W-1:0] prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '0;
        end else begin
            prev_q <= din;
        end
    end

    for (genvar i = 0; i < WORD_W; i++) begin : g_bit
        // polarity per bit, masked bits never count
        assign hit[i] = mask[i] & (compare[i] ? (din[i] & ~prev_q[i])
                                              : (~din[i] & prev_q[i]));
    end
endmodule : iei_edge
`default_nettype wire

// ### core/iei_unit.sv
// How it works
// - events are taken only when the configured group lies in the local chassis
// - an accepted event suspends main program, runs handler once, then resumes
// - an event arriving while the handler is busy sets the overlap bit
// - switching from main program to handler takes one millisecond
// - returning from handler to main program takes one millisecond
// - events are detected within 100 us; source spaces them 3 ms apart
// - watchdog keeps running and ignores reloads while the handler runs
// - counter mode counts events and triggers when the count reaches preset
// - bit-transition mode triggers on every qualifying event
// - staged configuration takes effect only on program to run transition
// - changed-bits word left nonzero at handler end sets the overlap bit
// - handler block transfers go after the active one, before queued ones
// - no event is taken while memory is reorganised for online edits
// - preset spans 0 to 32767; zero or one triggers on every event
// - compare bit one selects rising edge, zero selects falling edge
// - mask bit one monitors its input bit, zero ignores it
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iei_unit #(
    parameter int unsigned SWITCH_CYCLES = iei_pkg::SWITCH_CYC, // 1 ms context switch
    parameter int unsigned WDOG_CYCLES = iei_pkg::WDOG_CYC // watchdog timeout
) (
    input wire logic pclk, // system clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [iei_pkg::WORD_W-1:0] in_word, // input word of the local module
    input wire logic run_mode, // 1 run or test, 0 program
    input wire logic edit_busy, // memory reorganisation for online edit
    input wire logic bt_active, // a block transfer in the active buffer
    input wire logic bt_queued, // queued block transfer waiting
    output logic bt_grant_handler, // handler block transfer granted
    output logic bt_grant_queue, // queued block transfer granted
    output logic main_suspended, // main program held off
    output logic handler_run, // handler program executing
    output logic minor_fault, // overlap or not-local fault pending
    output logic wdog_expired, // watchdog timed out
    output logic irq // level interrupt
);
    import iei_pkg::*;

    iei_state_t state_q, state_d;
    iei_cfg_t stage_q, active_q;
    logic run_q;
    logic [31:0] sw_cnt_q;
    logic [31:0] wdog_q;
    logic [ACC_W-1:0] accum_q;
    logic [WORD_W-1:0] changed_q;
    logic [ST_W-1:0] status_q, irq_mask_q, st_set;
    logic bt_pend_q;
    logic [WORD_W-1:0] hit;
    logic event_any, group_local, accept, trigger, sw_done;
    logic wr, rd_setup, hnd_done_wr, kick_wr, bt_wr, chg_clr;
    logic addr_ok;

    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign hnd_done_wr = wr && paddr == ADDR_HANDLER && pwdata[HND_DONE_BIT];
    assign bt_wr = wr && paddr == ADDR_HANDLER && pwdata[HND_BT_BIT];
    assign kick_wr = wr && paddr == ADDR_HANDLER && pwdata[HND_KICK_BIT];
    assign chg_clr = wr && paddr == ADDR_CHANGED;

    always_comb begin
        case (paddr)
            ADDR_CTRL, ADDR_PRESET, ADDR_MASK, ADDR_COMPARE, ADDR_GROUP, ADDR_CHANGED,
            ADDR_ACCUM, ADDR_STATUS, ADDR_IRQ_MASK, ADDR_HANDLER, ADDR_STATE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;

    iei_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .din(in_word),
        .mask(active_q.mask),
        .compare(active_q.compare),
        .hit(hit)
    );

    // group rack number must be the resident chassis
    assign group_local = active_q.group[GROUP_RACK_LSB +: 4] == LOCAL_RACK;
    assign event_any = |hit;
    assign accept = event_any & group_local & run_q & ~edit_busy;
    always_comb begin
        if (!accept) begin
            trigger = 1'b0;
        end else if (!active_q.counter_mode || active_q.preset <= 15'h0001) begin
            trigger = 1'b1;
        end else begin
            trigger = (accum_q + 15'h0001) == active_q.preset;
        end
    end

    // staged config written by software, copied on program to run edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= CFG_RST;
        end else if (wr) begin
            case (paddr)
                ADDR_CTRL: stage_q.counter_mode <= pwdata[CTRL_MODE_BIT];
                ADDR_PRESET: stage_q.preset <= pwdata[PRESET_W-1:0];
                ADDR_MASK: stage_q.mask <= pwdata[WORD_W-1:0];
                ADDR_COMPARE: stage_q.compare <= pwdata[WORD_W-1:0];
                ADDR_GROUP: stage_q.group <= pwdata[7:0];
                default: stage_q <= stage_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            active_q <= CFG_RST;
        end else begin
            run_q <= run_mode;
            if (run_mode && !run_q) begin
                active_q <= stage_q;
            end
        end
    end

    assign sw_done = sw_cnt_q == SWITCH_CYCLES - 1;

    always_comb begin
        state_d = state_q;
        case (state_q)
            IEI_MAIN: if (trigger) state_d = IEI_SW_IN;
            IEI_SW_IN: if (sw_done) state_d = IEI_HANDLER;
            IEI_HANDLER: if (hnd_done_wr) state_d = IEI_SW_OUT;
            IEI_SW_OUT: if (sw_done) state_d = IEI_MAIN;
            default: state_d = IEI_MAIN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= IEI_MAIN;
            sw_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != state_d || state_q == IEI_MAIN || state_q == IEI_HANDLER) begin
                sw_cnt_q <= '0;
            end else begin
                sw_cnt_q <= sw_cnt_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_q <= '0;
        end else if (!active_q.counter_mode) begin
            accum_q <= '0;
        end else if (trigger) begin
            accum_q <= '0;
        end else if (accept) begin
            accum_q <= accum_q + 15'h0001;
        end
    end

    // set wins over the software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            changed_q <= '0;
        end else begin
            changed_q <= (chg_clr ? (changed_q & ~pwdata[WORD_W-1:0]) : changed_q)
                         | (accept ? hit : '0);
        end
    end

    always_comb begin
        st_set = '0;
        st_set[ST_TAKEN] = trigger && state_q == IEI_MAIN;
        st_set[ST_OVERLAP] = (trigger && state_q != IEI_MAIN)
                             || (hnd_done_wr && state_q == IEI_HANDLER
                                 && changed_q != '0);
        st_set[ST_NOT_LOCAL] = run_mode && !run_q && stage_q.group[GROUP_RACK_LSB +: 4]
                               != LOCAL_RACK;
        st_set[ST_DONE] = hnd_done_wr && state_q == IEI_HANDLER;
        st_set[ST_WDOG] = wdog_q == WDOG_CYCLES - 1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            irq_mask_q <= '0;
        end else begin
            status_q <= ((wr && paddr == ADDR_STATUS) ? (status_q & ~pwdata[ST_W-1:0])
                         : status_q) | st_set;
            if (wr && paddr == ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[ST_W-1:0];
            end
        end
    end

    // reload ignored while the handler side is busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_q <= '0;
        end else if (kick_wr && state_q == IEI_MAIN) begin
            wdog_q <= '0;
        end else if (wdog_q != WDOG_CYCLES - 1) begin
            wdog_q <= wdog_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt_pend_q <= 1'b0;
        end else if (bt_wr && state_q == IEI_HANDLER) begin
            bt_pend_q <= 1'b1;
        end else if (!bt_active) begin
            bt_pend_q <= 1'b0;
        end
    end
    assign bt_grant_handler = bt_pend_q & ~bt_active;
    assign bt_grant_queue = bt_queued & ~bt_active & ~bt_pend_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            case (paddr)
                ADDR_CTRL: prdata <= {31'h0, stage_q.counter_mode};
                ADDR_PRESET: prdata <= {17'h0, stage_q.preset};
                ADDR_MASK: prdata <= {16'h0, stage_q.mask};
                ADDR_COMPARE: prdata <= {16'h0, stage_q.compare};
                ADDR_GROUP: prdata <= {24'h0, stage_q.group};
                ADDR_CHANGED: prdata <= {16'h0, changed_q};
                ADDR_ACCUM: prdata <= {17'h0, accum_q};
                ADDR_STATUS: prdata <= {27'h0, status_q};
                ADDR_IRQ_MASK: prdata <= {27'h0, irq_mask_q};
                ADDR_STATE: prdata <= {28'h0, state_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign main_suspended = state_q != IEI_MAIN;
    assign handler_run = state_q == IEI_HANDLER;
    assign minor_fault = status_q[ST_OVERLAP] | status_q[ST_NOT_LOCAL];
    assign wdog_expired = status_q[ST_WDOG];
    assign irq = |(status_q & irq_mask_q);

    remote_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        event_any && !group_local |-> !trigger) else $error("event from non-local group");
    local_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_set[ST_NOT_LOCAL] |=> minor_fault)
        else $error("non-local group not flagged");
    run_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == IEI_MAIN && trigger |=> state_q == IEI_SW_IN)
        else $error("trigger did not leave main");
    overlap_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        trigger && state_q == IEI_HANDLER |=> status_q[ST_OVERLAP])
        else $error("overlap not flagged");
    switch_in_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == IEI_SW_IN && $past(state_q) == IEI_MAIN |-> sw_cnt_q == 0)
        else $error("switch count not restarted");
    switch_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q != IEI_SW_IN && state_q != IEI_SW_OUT |-> sw_cnt_q == 0)
        else $error("switch counter runs outside switch");
    wdog_runs_a: assert property (@(posedge pclk) disable iff (!presetn)
        handler_run && wdog_q < WDOG_CYCLES - 1 |=> wdog_q == $past(wdog_q) + 1)
        else $error("watchdog paused in handler");
    // a kick outside the main program must never bring the count back
    kick_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        kick_wr && state_q != IEI_MAIN && wdog_q != 0 |=> wdog_q != 0)
        else $error("watchdog reloaded outside main");
    counter_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept && active_q.counter_mode && active_q.preset > 15'h0001
        && accum_q + 15'h0001 != active_q.preset |-> !trigger)
        else $error("counter fired before preset");
    accum_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        trigger |=> accum_q == 0) else $error("accumulator not cleared");
    every_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept && !active_q.counter_mode |-> trigger)
        else $error("bit mode missed event");
    cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(run_mode && !run_q) |=> active_q == $past(active_q))
        else $error("config changed outside mode transition");
    done_overlap_a: assert property (@(posedge pclk) disable iff (!presetn)
        hnd_done_wr && state_q == IEI_HANDLER && changed_q != '0 |=> status_q[ST_OVERLAP])
        else $error("uncleared changed bits not flagged");
    edit_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        edit_busy |-> !trigger) else $error("trigger during edit");
    bt_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        bt_pend_q && !bt_active |-> bt_grant_handler && !bt_grant_queue)
        else $error("queued transfer passed handler");
    bt_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        bt_wr && state_q == IEI_HANDLER |=> bt_pend_q)
        else $error("handler transfer request lost");
    // a counted bit must sit at the level its polarity selects
    polarity_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        (hit & (in_word ^ active_q.compare)) == '0)
        else $error("event on wrong edge");
    mask_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        (hit & ~active_q.mask) == '0)
        else $error("unmonitored bit produced an event");
endmodule : iei_unit
`default_nettype wire

// ### tb/iei_input_model.sv
`timescale 1ns/1ps
`default_nettype none
module iei_input_model #(
    parameter int GAP = 4 // hold count; a level is held at least GAP + 1 cycles
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [iei_pkg::WORD_W-1:0] want, // level asked for by the bench
    output logic [iei_pkg::WORD_W-1:0] in_word // input word seen by the unit
);
    import iei_pkg::*;
    logic [WORD_W-1:0] word_q;
    int gap_q;
    assign in_word = word_q;
    // a new level only after the previous one was held, so events stay spaced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_q <= '0;
            gap_q <= 0;
        end else if (gap_q != 0) begin
            gap_q <= gap_q - 1;
        end else if (want != word_q) begin
            word_q <= want;
            gap_q <= GAP;
        end
    end
endmodule : iei_input_model
`default_nettype wire

// ### tb/input_event_interrupt_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module input_event_interrupt_unit_tb;
    import iei_pkg::*;
    localparam int SW = 8;
    localparam int WD = 64;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [WORD_W-1:0] want, in_word;
    logic run_mode, edit_busy, bt_active, bt_queued, bt_grant_handler, bt_grant_queue;
    logic main_suspended, handler_run, minor_fault, wdog_expired, irq;
    int err_count = 0;
    int samples_checked = 0;
    always #5 pclk = ~pclk;
    iei_unit #(.SWITCH_CYCLES(SW), .WDOG_CYCLES(WD)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_word(in_word),
        .run_mode(run_mode), .edit_busy(edit_busy), .bt_active(bt_active),
        .bt_queued(bt_queued), .bt_grant_handler(bt_grant_handler),
        .bt_grant_queue(bt_grant_queue), .main_suspended(main_suspended),
        .handler_run(handler_run), .minor_fault(minor_fault),
        .wdog_expired(wdog_expired), .irq(irq));
    iei_input_model #(.GAP(4)) src (.pclk(pclk), .presetn(presetn), .want(want),
        .in_word(in_word));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] msk = 32'hFFFFFFFF);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r & msk, exp);
    endtask : rdc
    task automatic drive_in(input logic [WORD_W-1:0] w);
        int n;
        want <= w;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (in_word !== w && n < 20);
        if (n >= 20) begin
            err_count++;
            report_and_stop();
        end
    endtask : drive_in
    // 0: suspended, 1: handler running, 2: back in main program
    task automatic wait_for(input int which, output int n);
        logic ok;
        n = 0;
        forever begin
            @(posedge pclk);
            n++;
            case (which)
                0: ok = (main_suspended === 1'b1);
                1: ok = (handler_run === 1'b1);
                default: ok = (main_suspended === 1'b0);
            endcase
            if (ok || n >= 200) break;
        end
        if (!ok) begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_for
    task automatic pulse;
        drive_in(16'h0001);
        drive_in(16'h0000);
    endtask : pulse
    task automatic serve;
        int n;
        wait_for(1, n);
        wr(ADDR_CHANGED, 32'hFFFF);
        wr(ADDR_HANDLER, 32'h1);
        wait_for(2, n);
    endtask : serve
    task automatic reconfig(input logic [31:0] c, input logic [31:0] p, input logic [31:0] g);
        run_mode <= 1'b0;
        wr(ADDR_CTRL, c);
        wr(ADDR_PRESET, p);
        wr(ADDR_GROUP, g);
        wr(ADDR_STATUS, 32'h1F);
        run_mode <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : reconfig

    initial begin
        logic [31:0] r;
        logic e;
        int n;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = '0;
        run_mode = 1'b0;
        edit_busy = 1'b0;
        bt_active = 1'b0;
        bt_queued = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ADDR_STATE, 32'h1);
        rdc(ADDR_PRESET, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r, e);
        check(e, 1'b1);
        check(r, 32'h0);
        $display("test reset done");
        wr(ADDR_MASK, 32'h0005);
        wr(ADDR_COMPARE, 32'h0001);
        wr(ADDR_IRQ_MASK, 32'h01);
        rdc(ADDR_MASK, 32'h0005);
        pulse();
        repeat (10) @(posedge pclk);
        check(main_suspended, 1'b0);
        reconfig(32'h0, 32'h0, 32'h0);
        wr(ADDR_HANDLER, 32'h4);
        drive_in(16'h0006);
        repeat (10) @(posedge pclk);
        check(main_suspended, 1'b0);
        drive_in(16'h0000);
        wait_for(0, n);
        check(32'(n <= 10000), 32'h1);
        wait_for(1, n);
        check(32'(n), 32'(SW));
        wr(ADDR_HANDLER, 32'h4);
        n = 0;
        while (wdog_expired !== 1'b1 && n < WD) begin
            @(posedge pclk);
            n++;
        end
        check(wdog_expired, 1'b1);
        check(irq, 1'b1);
        rdc(ADDR_CHANGED, 32'h4);
        bt_active <= 1'b1;
        bt_queued <= 1'b1;
        wr(ADDR_HANDLER, 32'h2);
        check({bt_grant_handler, bt_grant_queue}, 2'b00);
        bt_active <= 1'b0;
        @(posedge pclk);
        check({bt_grant_handler, bt_grant_queue}, 2'b10);
        @(posedge pclk);
        check({bt_grant_handler, bt_grant_queue}, 2'b01);
        bt_queued <= 1'b0;
        drive_in(16'h0004);
        drive_in(16'h0000);
        @(posedge pclk);
        check(minor_fault, 1'b1);
        rdc(ADDR_STATE, 32'h4);
        wr(ADDR_STATUS, 32'h1F);
        check(minor_fault, 1'b0);
        wr(ADDR_HANDLER, 32'h1);
        wait_for(2, n);
        check(32'(n), 32'(SW));
        rdc(ADDR_STATUS, 32'h0A, 32'h0A);
        rdc(ADDR_STATE, 32'h1);
        $display("test bit transition done");
        wr(ADDR_CHANGED, 32'hFFFF);
        wr(ADDR_STATUS, 32'h1F);
        wr(ADDR_IRQ_MASK, 32'h00);
        edit_busy <= 1'b1;
        drive_in(16'h0004);
        drive_in(16'h0000);
        repeat (10) @(posedge pclk);
        check(main_suspended, 1'b0);
        edit_busy <= 1'b0;
        reconfig(32'h0, 32'h5, 32'h0);
        pulse();
        check(main_suspended, 1'b1);
        check(irq, 1'b0);
        serve();
        $display("test edit and every event done");
        reconfig(32'h1, 32'h3, 32'h0);
        repeat (2) pulse();
        check(main_suspended, 1'b0);
        rdc(ADDR_ACCUM, 32'h2);
        pulse();
        check(main_suspended, 1'b1);
        rdc(ADDR_ACCUM, 32'h0);
        serve();
        for (int p = 0; p < 2; p++) begin
            reconfig(32'h1, 32'(p), 32'h0);
            pulse();
            check(main_suspended, 1'b1);
            serve();
        end
        $display("test counter done");
        reconfig(32'h0, 32'h0, 32'h10);
        check(minor_fault, 1'b1);
        pulse();
        repeat (10) @(posedge pclk);
        check(main_suspended, 1'b0);
        $display("test remote group done");
        report_and_stop();
    end
endmodule : input_event_interrupt_unit_tb
`default_nettype wire
